// [ebws_pkg.sv]
// package for the external bus wait-state status outputs
// assumes a single 20 MHz core clock and an active-low async reset
//
// Function
// R1: with two or more wait states the done pin drops at the first one.
// R2: the done pin returns high at the start of the last wait state.
// R3: done looped to ready stretches the access by one external wait.
// R4: while the float control is low the done pin is not driven.
// R5: the fetch flag is low during a fetch address and high otherwise.
// R6: while the float control is low the fetch flag is not driven.
// R7: the machine clock toggles once per cycle, rising edge to rising edge.
// R8: while the float control is low the machine clock is not driven.
// R9: ready seen low makes the access wait a cycle and look again.
// R10: ready counts only with two or more wait states, after they end.
// R11: outside a wait sequence or below two wait states done stays high.
package ebws_pkg;
   // =====================================================
   // constants
   localparam int EBWS_WS_W = 3;
   localparam logic [2:0] EBWS_MIN_WS_READY = 3'h2;
   localparam logic [2:0] EBWS_WS_ZERO = 3'h0;

   // =====================================================
   // types
   typedef enum logic [1:0] {
      EBWS_IDLE = 2'b00,
      EBWS_SWWAIT = 2'b01,
      EBWS_RDYWAIT = 2'b10
   } ebws_state_t;

   typedef struct packed {
      logic out;
      logic oe;
   } ebws_pin_t;
endpackage

// [ebws_status.sv]
// wait-state status pin driver of the parallel memory interface
// assumes access requests and fetch flag come from logic on CLOCK;
// READY and NOFF are pins and are synchronised here
`timescale 1ns/1ps
`default_nettype none
module ebws_status (
   input wire logic CLOCK,
   input wire logic NRST,
   input wire logic ACCESS_START,
   input wire logic [ebws_pkg::EBWS_WS_W-1:0] WAIT_STATES,
   input wire logic FETCH_CYCLE,
   input wire logic READY,
   input wire logic NOFF,
   output logic ACCESS_DONE,
   output ebws_pkg::ebws_pin_t WAIT_STATE_DONE_OUT,
   output ebws_pkg::ebws_pin_t INSTR_FETCH_FLAG,
   output ebws_pkg::ebws_pin_t MACHINE_CLOCK_OUT
);
   import ebws_pkg::*;

   // =====================================================
   // pin synchronisers
   // both pins are asynchronous to CLOCK; only the second flop is read
   wire logic ready_sync;
   wire logic drive_en;

   // ready idles low through reset so no access ends on a stale high;
   // the synchroniser adds two cycles before ready can end an access
   ebws_sync #(
      .RESET_VAL(1'b0)
   ) ready_sync_i (
      .clk(CLOCK),
      .nrst(NRST),
      .pin(READY),
      .sync(ready_sync)
   );

   // outputs stay floated until the float control has been seen high
   ebws_sync #(
      .RESET_VAL(1'b0)
   ) float_sync_i (
      .clk(CLOCK),
      .nrst(NRST),
      .pin(NOFF),
      .sync(drive_en)
   );

   // =====================================================
   // access sequencer state
   // no access can be queued: a start outside idle is dropped
   ebws_state_t state_reg;
   ebws_state_t state_next;
   logic [EBWS_WS_W-1:0] cnt_reg;
   logic [EBWS_WS_W-1:0] cnt_next;
   logic chk_rdy_reg;
   logic chk_rdy_next;
   logic done_reg;
   logic done_next;
   logic mclk_reg;
   logic mclk_next;
   logic fetch_reg;
   logic fetch_next;
   logic access_done;

   // =====================================================
   // decoding
   // the wait count is only valid with the start strobe, so the ready
   // decision is taken once and held for the rest of the access
   wire logic zero_ws = (WAIT_STATES == EBWS_WS_ZERO);
   wire logic ready_checked = (WAIT_STATES >= EBWS_MIN_WS_READY); // [R10]
   wire logic last_ws = (cnt_reg == EBWS_WS_W'(1));
   // a count of two or less means the next wait state is the last one
   wire logic next_last = (cnt_reg <= EBWS_MIN_WS_READY);
   wire logic [EBWS_WS_W-1:0] cnt_dec = cnt_reg - EBWS_WS_W'(1);

   // =====================================================
   // next state
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      chk_rdy_next = chk_rdy_reg;
      done_next = 1'b1; // [R11]
      access_done = 1'b0;
      case (state_reg)
         EBWS_IDLE: begin
            if (ACCESS_START) begin
               if (zero_ws) begin
                  access_done = 1'b1;
               end else begin
                  state_next = EBWS_SWWAIT;
                  cnt_next = WAIT_STATES;
                  chk_rdy_next = ready_checked;
                  done_next = !ready_checked; // [R1]
               end
            end
         end
         EBWS_SWWAIT: begin
            // low through all but the last software wait state
            done_next = !chk_rdy_reg || next_last; // [R2]
            if (last_ws) begin
               cnt_next = EBWS_WS_ZERO;
               if (chk_rdy_reg) begin
                  state_next = EBWS_RDYWAIT; // [R10]
               end else begin
                  state_next = EBWS_IDLE;
                  access_done = 1'b1;
               end
            end else begin
               cnt_next = cnt_dec;
            end
         end
         EBWS_RDYWAIT: begin
            // done pin looped to ready is seen low here one cycle, forcing
            // a single extra external wait state before completion
            if (ready_sync) begin // [R9] [R3]
               state_next = EBWS_IDLE;
               access_done = 1'b1;
            end
         end
         default: begin
            state_next = EBWS_IDLE;
            cnt_next = EBWS_WS_ZERO;
            chk_rdy_next = 1'b0;
         end
      endcase
   end

   // free-running pins: the clock pin halves CLOCK, the flag is an inverted
   // one-cycle delay so it lines up with the registered address bus
   assign mclk_next = !mclk_reg; // [R7]
   assign fetch_next = !FETCH_CYCLE; // [R5]

   // =====================================================
   // registers
   // all resets are constants; the fetch flag and done pin idle high
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         state_reg <= EBWS_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         cnt_reg <= EBWS_WS_ZERO;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         chk_rdy_reg <= 1'b0;
      end else begin
         chk_rdy_reg <= chk_rdy_next;
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         done_reg <= 1'b1;
      end else begin
         done_reg <= done_next;
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         mclk_reg <= 1'b0;
      end else begin
         mclk_reg <= mclk_next;
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         fetch_reg <= 1'b1;
      end else begin
         fetch_reg <= fetch_next;
      end
   end

   // =====================================================
   // pin drivers; float control overrides every enable
   // the pads and any pull-ups on these lines sit outside this block
   assign ACCESS_DONE = access_done;
   assign WAIT_STATE_DONE_OUT = '{out: done_reg, oe: drive_en}; // [R4]
   assign INSTR_FETCH_FLAG = '{out: fetch_reg, oe: drive_en}; // [R6]
   assign MACHINE_CLOCK_OUT = '{out: mclk_reg, oe: drive_en}; // [R8]
endmodule

// =====================================================
// two-flop synchroniser for one asynchronous pin
// only the second flop is read; the first may go metastable
module ebws_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic pin,
   output logic sync
);
   logic meta_reg;
   logic sync_reg;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= RESET_VAL;
      end else begin
         meta_reg <= pin;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync_reg <= RESET_VAL;
      end else begin
         sync_reg <= meta_reg;
      end
   end

   assign sync = sync_reg;
endmodule
`default_nettype wire

// [ebws_properties.sv]
// assertions on the status pins, bound into ebws_status
// assumes the bench issues access starts only while the block is idle
`timescale 1ns/1ps
`default_nettype none
module ebws_chk (
   input wire logic CLOCK,
   input wire logic NRST,
   input wire logic ACCESS_START,
   input wire logic FETCH_CYCLE,
   input wire logic NOFF,
   input wire logic ACCESS_DONE,
   input wire logic [ebws_pkg::EBWS_WS_W-1:0] WAIT_STATES,
   input wire ebws_pkg::ebws_pin_t WAIT_STATE_DONE_OUT,
   input wire ebws_pkg::ebws_pin_t INSTR_FETCH_FLAG,
   input wire ebws_pkg::ebws_pin_t MACHINE_CLOCK_OUT
);
   import ebws_pkg::*;
   // ==========================================================
   // wait states still to run, as seen from the pins
   logic [2:0] left_reg;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!NRST);
   always_ff @(posedge CLOCK or negedge NRST)
      if (!NRST) left_reg <= EBWS_WS_ZERO;
      else if (left_reg != EBWS_WS_ZERO) left_reg <= left_reg - 3'h1;
      else if (ACCESS_START) left_reg <= WAIT_STATES;
   a_done_window:
      assert property (WAIT_STATE_DONE_OUT.out == (left_reg < 3'h2))
      else $error("done pin level wrong");
   a_ready_late:
      assert property (left_reg > 3'h1 |-> !ACCESS_DONE)
      else $error("access ended inside software wait states");
   a_zero_ws:
      assert property (ACCESS_START && left_reg == EBWS_WS_ZERO &&
         WAIT_STATES == EBWS_WS_ZERO |-> ACCESS_DONE)
      else $error("zero wait access not done at once");
   a_fetch_follow:
      assert property ($past(NRST) |->
         INSTR_FETCH_FLAG.out == !$past(FETCH_CYCLE))
      else $error("fetch flag wrong");
   a_mclk_toggle:
      assert property ($past(NRST) |-> $changed(MACHINE_CLOCK_OUT.out))
      else $error("machine clock stuck");
   a_done_float:
      assert property ($past(NRST) && $past(NRST, 2) |->
         WAIT_STATE_DONE_OUT.oe == $past(NOFF, 2))
      else $error("done pin enable wrong");
   a_fetch_float:
      assert property ($past(NRST) && $past(NRST, 2) |->
         INSTR_FETCH_FLAG.oe == $past(NOFF, 2))
      else $error("fetch pin enable wrong");
   a_mclk_float:
      assert property ($past(NRST) && $past(NRST, 2) |->
         MACHINE_CLOCK_OUT.oe == $past(NOFF, 2))
      else $error("clock pin enable wrong");
endmodule
bind ebws_status ebws_chk chk (.*);
`default_nettype wire

// [ebws_mem.sv]
// far-side memory: ready held low while slow, or looped from the done pin
// assumes a board pull-up on the ready line
`timescale 1ns/1ps
`default_nettype none
module ebws_mem (
   input wire logic loop_en,
   input wire logic slow,
   input wire ebws_pkg::ebws_pin_t done_pin,
   output logic ready
);
   // a floated done pin reads high through the pull-up
   wire logic pin_level = !done_pin.oe || done_pin.out;
   assign ready = loop_en ? pin_level : !slow;
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the status pins
// assumes the memory model as the only driver of ready
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ebws_pkg::*;
   logic clk = 1'h0, nrst = 1'h0, start = 1'h0, fetch = 1'h0, noff = 1'h1;
   logic lp = 1'h0, slow = 1'h0, ready, done;
   logic [2:0] ws = 3'h0;
   ebws_pin_t wsd, fpin, mclk;
   int mismatches = 0, cmp_count = 0;
   ebws_status dut (.CLOCK(clk), .NRST(nrst), .ACCESS_START(start),
      .WAIT_STATES(ws), .FETCH_CYCLE(fetch), .READY(ready), .NOFF(noff),
      .ACCESS_DONE(done), .WAIT_STATE_DONE_OUT(wsd),
      .INSTR_FETCH_FLAG(fpin), .MACHINE_CLOCK_OUT(mclk));
   ebws_mem mem (.loop_en(lp), .slow(slow), .done_pin(wsd), .ready(ready));
   initial forever #25 clk = ~clk;
   task chk(input logic [3:0] seen, input logic [3:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task print_verdict;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ==========================================================
   // one access, counting cycles until done; a slow device lets go late
   task acc(input logic [2:0] n, input logic [3:0] exp);
      logic [3:0] k;
      logic [3:0] lo;
      logic [3:0] lo_exp;
      k = 4'h0;
      lo = 4'h0;
      lo_exp = (n < 3'h2) ? 4'h0 : {1'h0, n - 3'h1};
      ws = n;
      start = 1'h1;
      #1;
      while (done !== 1'h1 && k < 4'hC) begin
         @(negedge clk);
         start = 1'h0;
         if (k == 4'h5) slow = 1'h0;
         k++;
         #1;
         if (wsd.out === 1'h0) lo++;
      end
      chk(k, exp, "access cycles");
      chk(lo, lo_exp, "done low cycles");
      @(negedge clk);
      start = 1'h0;
      @(negedge clk);
   endtask
   task t_access;
      acc(3'h0, 4'h0);
      acc(3'h1, 4'h1);
      acc(3'h3, 4'h4);
      slow = 1'h1;
      acc(3'h2, 4'h8);
      lp = 1'h1;
      acc(3'h3, 4'h5);
      lp = 1'h0;
   endtask
   // an access cut by reset leaves the pins idle and the next one runs
   task t_reset;
      ws = 3'h3;
      start = 1'h1;
      @(negedge clk);
      start = 1'h0;
      nrst = 1'h0;
      #1;
      chk({2'h0, wsd.out, fpin.out}, 4'h3, "reset pins");
      chk({3'h0, done}, 4'h0, "reset access done");
      @(negedge clk);
      nrst = 1'h1;
      @(negedge clk);
      acc(3'h3, 4'h4);
   endtask
   task t_pins;
      logic m;
      fetch = 1'h1;
      m = mclk.out;
      @(negedge clk);
      chk({3'h0, fpin.out}, 4'h0, "fetch flag");
      chk({3'h0, mclk.out}, {3'h0, ~m}, "machine clock");
      fetch = 1'h0;
      noff = 1'h0;
      repeat (3) @(negedge clk);
      chk({1'h0, wsd.oe, fpin.oe, mclk.oe}, 4'h0, "enables");
      noff = 1'h1;
      repeat (3) @(negedge clk);
      chk({1'h0, wsd.oe, fpin.oe, mclk.oe}, 4'h7, "enables");
   endtask
   initial begin
      repeat (2) @(negedge clk);
      nrst = 1'h1;
      @(negedge clk);
      t_pins;
      t_access;
      t_reset;
      print_verdict;
   end
   initial begin
      #20000;
      mismatches++;
      print_verdict;
   end
endmodule
`default_nettype wire
